//--- hw/ccr_pkg.sv
// Purpose: Shared constants and types for the charger config register bank
// Assumes: 8-bit registers behind a two-wire serial slave
// Notes:   All offsets, reset values and scale figures live here
`default_nettype none
package ccr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h02;
  localparam logic [7:0] BVC_ADDR  = 8'h03;
  localparam logic [7:0] VPR_ADDR  = 8'h04;
  localparam logic [7:0] CTC_ADDR  = 8'h05;
  localparam logic [7:0] DPM_ADDR  = 8'h06;
  localparam logic [6:0] DEV_ADDR  = 7'h6b;

  localparam logic [6:0] CTRL_RST  = 7'h0c;
  localparam logic [7:0] BVC_RST   = 8'h14;
  localparam logic [7:0] CTC_RST   = 8'h32;
  localparam logic [5:0] DPM_RST   = 6'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_HZ_BIT  = 0;
  localparam int CTRL_CHG_OFF_BIT = 1;
  localparam int BVC_FORCE_BIT = 0;
  localparam int BVC_ILIM_BIT  = 1;

  // ----------------------------------------------------------------------
  // Scale figures
  // ----------------------------------------------------------------------
  localparam logic [5:0]  BATT_MAX_CODE   = 6'h2f;
  localparam logic [12:0] BATT_BASE_MV    = 13'h0dac;
  localparam logic [12:0] BATT_STEP_MV    = 13'h0014;
  localparam logic [11:0] ILIM_LOW_MA     = 12'h5dc;
  localparam logic [11:0] ILIM_HIGH_MA    = 12'h9c4;
  localparam logic [11:0] ICHG_BASE_MA    = 12'h226;
  localparam logic [11:0] ICHG_STEP_MA    = 12'h04b;
  localparam logic [11:0] TERM_BASE_MA    = 12'h032;
  localparam logic [11:0] TERM_STEP_MA    = 12'h032;
  localparam logic [12:0] VDPM_BASE_MV    = 13'h1068;
  localparam logic [12:0] VDPM_STEP_MV    = 13'h0050;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ccr_wr_t;

  typedef struct packed {
    logic converter_on;
    logic charge_run;
    logic system_rail_target;
    logic battery_switch_on;
    logic battery_switch_gate;
    logic low_quiescent;
  } ccr_power_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_PTR   = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK  = 3'b110
  } ccr_state_t;

endpackage
`default_nettype wire

//--- hw/ccr_i2c_slave.sv
// Purpose: Two-wire serial slave giving byte access to the register bank
// Assumes: Pointer byte after address on writes; reads start at pointer
// Notes:   Pointer advances per data byte; open-drain data pin
`timescale 1ns/1ps
`default_nettype none
module ccr_i2c_slave (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  output ccr_pkg::ccr_wr_t     wr,
  output logic [7:0]           rd_addr,
  input  wire logic [7:0]      rd_data
);

  logic [1:0]          scl_sync;
  logic [1:0]          sda_sync;
  logic                scl_d;
  logic                sda_d;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  ccr_pkg::ccr_state_t state;
  logic [7:0]          shift;
  logic [3:0]          cnt;
  logic                is_read;
  logic                ptr_done;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  assign scl_rise  = scl_sync[1] & ~scl_d;
  assign scl_fall  = ~scl_sync[1] & scl_d;
  assign start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_det  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // ----------------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ccr_pkg::ST_IDLE;
      shift    <= 8'h00;
      cnt      <= 4'h0;
      is_read  <= 1'b0;
      ptr_done <= 1'b0;
      rd_addr  <= 8'h00;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
      wr       <= '0;
    end else begin
      wr.valid <= 1'b0;
      if (start_det) begin
        state    <= ccr_pkg::ST_ADDR;
        cnt      <= 4'h0;
        ptr_done <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (stop_det) begin
        state  <= ccr_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ccr_pkg::ST_ADDR, ccr_pkg::ST_PTR, ccr_pkg::ST_WDATA: begin
            shift <= {shift[6:0], sda_sync[1]};
            cnt   <= cnt + 4'h1;
          end
          ccr_pkg::ST_RACK: begin
            // Master NACK ends the read burst
            if (sda_sync[1]) begin
              state <= ccr_pkg::ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ccr_pkg::ST_ADDR: begin
            if (cnt == 4'h8) begin
              if (shift[7:1] == ccr_pkg::DEV_ADDR) begin
                is_read <= shift[0];
                sda_oe  <= 1'b1;
                state   <= ccr_pkg::ST_ACK;
              end else begin
                state <= ccr_pkg::ST_IDLE;
              end
            end
          end
          ccr_pkg::ST_PTR: begin
            if (cnt == 4'h8) begin
              rd_addr  <= shift;
              ptr_done <= 1'b1;
              sda_oe   <= 1'b1;
              state    <= ccr_pkg::ST_ACK;
            end
          end
          ccr_pkg::ST_WDATA: begin
            if (cnt == 4'h8) begin
              wr.valid <= 1'b1;
              wr.addr  <= rd_addr;
              wr.data  <= shift;
              rd_addr  <= rd_addr + 8'h01;
              sda_oe   <= 1'b1;
              state    <= ccr_pkg::ST_ACK;
            end
          end
          ccr_pkg::ST_ACK, ccr_pkg::ST_RACK: begin
            cnt <= 4'h1;
            if (is_read) begin
              sda_oe  <= ~rd_data[7];
              shift   <= {rd_data[6:0], 1'b0};
              rd_addr <= rd_addr + 8'h01;
              state   <= ccr_pkg::ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              cnt    <= 4'h0;
              state  <= ptr_done ? ccr_pkg::ST_WDATA : ccr_pkg::ST_PTR;
            end
          end
          ccr_pkg::ST_RDATA: begin
            if (cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state  <= ccr_pkg::ST_RACK;
            end else begin
              sda_oe <= ~shift[7];
              shift  <= {shift[6:0], 1'b0};
              cnt    <= cnt + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/ccr_cfg_regs.sv
// Purpose: Charger configuration register bank and power-path control
// Assumes: One 125 MHz clock; analog status arrives asynchronously
// Notes:   Registers reached over the two-wire serial slave only
//
// Operation
// - Charging runs while the charge-disable and high-impedance bits are both 0 and stops when either is 1.
// - Charge off: rail regulated, battery cut off except for supplement.
// - High-impedance bit 1 selects low quiescent state, 0 returns to normal.
// - High-impedance: converter off, battery switch and gate on.
// - Bits 7:2 of 0x03 set 3.5 V plus 20 mV per step, default 3.6 V.
// - Bit 1 of 0x03 sets the high-power input limit, 1.5 A or 2.5 A.
// - Writing 1 to bit 0 of 0x03 forces USB detection until done.
// - Register 0x04 is read-only vendor, part and revision codes.
// - Bits 7:3 of 0x05 set fast charge as 550 mA plus 75 mA per step.
// - Bits 2:0 of 0x05 set termination as 50 mA plus 50 mA per step.
// - Bit 7 of 0x06 reads 1 while minimum system voltage mode is active.
// - Bit 6 of 0x06 reads 1 while input power limiting is active.
// - Bits 5:3 of 0x06 set USB input threshold, 4.20 V in 80 mV steps.
// - Charge-disable is bit 1 and high-impedance bit 0 of register 0x02.
`timescale 1ns/1ps
`default_nettype none
module ccr_cfg_regs #(
  parameter logic [2:0] VENDOR_CODE   = 3'h5, // Arbitrary value
  parameter logic [1:0] PART_CODE     = 2'h2, // Arbitrary value
  parameter logic [2:0] REVISION_CODE = 3'h3  // Arbitrary value
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  input  wire logic          min_system_active_pin,
  input  wire logic          input_power_limit_pin,
  input  wire logic          supply_short_pin,
  input  wire logic          usb_detect_done_pin,
  output ccr_pkg::ccr_power_t power_path,
  output logic               usb_detect_force,
  output logic [12:0]        battery_reg_target_mv,
  output logic [11:0]        hp_input_current_limit_ma,
  output logic [11:0]        fast_charge_current_ma,
  output logic [11:0]        termination_current_ma,
  output logic [12:0]        usb_input_power_limit_mv,
  output logic [12:0]        hp_input_power_limit_mv
);

  ccr_pkg::ccr_wr_t wr;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  logic [3:0]       pin_meta;
  logic [3:0]       pin_sync;
  logic [6:0]       ctrl;
  logic [7:1]       bvc_hi;
  logic [7:0]       ctc;
  logic [5:0]       dpm_thr;
  logic             min_system_active_flag;
  logic             input_power_limit_flag;
  logic             supply_short;
  logic             usb_detect_done;
  logic [5:0]       batt_code;

  // ----------------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------------
  ccr_i2c_slave u_slave (
    .sys_clk (sys_clk),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------------
  // Analog status synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {usb_detect_done_pin, supply_short_pin,
                   input_power_limit_pin, min_system_active_pin};
      pin_sync <= pin_meta;
    end
  end

  assign min_system_active_flag = pin_sync[0];
  assign input_power_limit_flag = pin_sync[1];
  assign supply_short           = pin_sync[2];
  assign usb_detect_done        = pin_sync[3];

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= ccr_pkg::CTRL_RST;
    end else if (wr.valid && wr.addr == ccr_pkg::CTRL_ADDR) begin
      ctrl <= wr.data[6:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bvc_hi <= ccr_pkg::BVC_RST[7:1];
    end else if (wr.valid && wr.addr == ccr_pkg::BVC_ADDR) begin
      bvc_hi <= wr.data[7:1];
    end
  end

  // A new force request beats a completion seen in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      usb_detect_force <= ccr_pkg::BVC_RST[ccr_pkg::BVC_FORCE_BIT];
    end else if (wr.valid && wr.addr == ccr_pkg::BVC_ADDR) begin
      usb_detect_force <= wr.data[ccr_pkg::BVC_FORCE_BIT];
    end else if (usb_detect_done) begin
      usb_detect_force <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctc <= ccr_pkg::CTC_RST;
    end else if (wr.valid && wr.addr == ccr_pkg::CTC_ADDR) begin
      ctc <= wr.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dpm_thr <= ccr_pkg::DPM_RST;
    end else if (wr.valid && wr.addr == ccr_pkg::DPM_ADDR) begin
      dpm_thr <= wr.data[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    if (rd_addr == ccr_pkg::CTRL_ADDR) begin
      rd_data = {1'b1, ctrl};
    end else if (rd_addr == ccr_pkg::BVC_ADDR) begin
      rd_data = {bvc_hi, usb_detect_force};
    end else if (rd_addr == ccr_pkg::VPR_ADDR) begin
      rd_data = {VENDOR_CODE, PART_CODE, REVISION_CODE};
    end else if (rd_addr == ccr_pkg::CTC_ADDR) begin
      rd_data = ctc;
    end else if (rd_addr == ccr_pkg::DPM_ADDR) begin
      rd_data = {min_system_active_flag, input_power_limit_flag,
                 dpm_thr};
    end else begin
      rd_data = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Power path
  // ----------------------------------------------------------------------
  // Register writes are not checked against a pending overvoltage fault;
  // clearing it first is up to the host.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_path <= '0;
    end else if (ctrl[ccr_pkg::CTRL_HZ_BIT]) begin
      power_path.converter_on        <= 1'b0;
      power_path.charge_run          <= 1'b0;
      power_path.system_rail_target  <= 1'b0;
      power_path.battery_switch_on   <= 1'b1;
      power_path.battery_switch_gate <= 1'b1;
      power_path.low_quiescent       <= 1'b1;
    end else if (ctrl[ccr_pkg::CTRL_CHG_OFF_BIT]) begin
      power_path.converter_on        <= 1'b1;
      power_path.charge_run          <= 1'b0;
      power_path.system_rail_target  <= 1'b1;
      power_path.battery_switch_on   <= supply_short;
      power_path.battery_switch_gate <= supply_short;
      power_path.low_quiescent       <= 1'b0;
    end else begin
      power_path.converter_on        <= 1'b1;
      power_path.charge_run          <= 1'b1;
      power_path.system_rail_target  <= 1'b0;
      power_path.battery_switch_on   <= 1'b1;
      power_path.battery_switch_gate <= 1'b1;
      power_path.low_quiescent       <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Regulation targets
  // ----------------------------------------------------------------------
  // Codes past the ceiling would drive the cell beyond its rating
  assign batt_code = (bvc_hi[7:2] > ccr_pkg::BATT_MAX_CODE) ?
                     ccr_pkg::BATT_MAX_CODE : bvc_hi[7:2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      battery_reg_target_mv     <= 13'h0000;
      hp_input_current_limit_ma <= 12'h000;
      fast_charge_current_ma    <= 12'h000;
      termination_current_ma    <= 12'h000;
      usb_input_power_limit_mv  <= 13'h0000;
      hp_input_power_limit_mv   <= 13'h0000;
    end else begin
      battery_reg_target_mv <= ccr_pkg::BATT_BASE_MV +
        13'(ccr_pkg::BATT_STEP_MV * {7'h00, batt_code});
      hp_input_current_limit_ma <= bvc_hi[ccr_pkg::BVC_ILIM_BIT] ?
        ccr_pkg::ILIM_HIGH_MA : ccr_pkg::ILIM_LOW_MA;
      fast_charge_current_ma <= ccr_pkg::ICHG_BASE_MA +
        12'(ccr_pkg::ICHG_STEP_MA * {7'h00, ctc[7:3]});
      termination_current_ma <= ccr_pkg::TERM_BASE_MA +
        12'(ccr_pkg::TERM_STEP_MA * {9'h000, ctc[2:0]});
      usb_input_power_limit_mv <= ccr_pkg::VDPM_BASE_MV +
        13'(ccr_pkg::VDPM_STEP_MV * {10'h000, dpm_thr[5:3]});
      hp_input_power_limit_mv <= ccr_pkg::VDPM_BASE_MV +
        13'(ccr_pkg::VDPM_STEP_MV * {10'h000, dpm_thr[2:0]});
    end
  end

endmodule
`default_nettype wire

//--- dv/ccr_cfg_regs_asserts.sv
// Purpose: Port-level checks for the charger config register bank
// Assumes: Outputs read zero in reset and on the first edge after
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module ccr_cfg_regs_asserts (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                supply_short_pin,
  input wire logic                usb_detect_done_pin,
  input wire ccr_pkg::ccr_power_t power_path,
  input wire logic                usb_detect_force,
  input wire logic [12:0]         battery_reg_target_mv,
  input wire logic [11:0]         hp_input_current_limit_ma,
  input wire logic [11:0]         fast_charge_current_ma,
  input wire logic [11:0]         termination_current_ma,
  input wire logic [12:0]         usb_input_power_limit_mv,
  input wire logic [12:0]         hp_input_power_limit_mv
);
  wire [12:0] vb = battery_reg_target_mv;
  wire [11:0] ic = fast_charge_current_ma;
  wire [11:0] it = termination_current_ma;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------
  // Sequences
  // ------------------------------------
  sequence s_cd_mode;
    power_path.converter_on && !power_path.charge_run;
  endsequence
  sequence s_short_held;
    s_cd_mode ##0 supply_short_pin [*4];
  endsequence
  // Two sync flops plus the register: three edges
  sequence s_done_held;
    $rose(usb_detect_done_pin) && usb_detect_force
      ##1 usb_detect_done_pin [*3];
  endsequence
  chk_hz_quiet: assert property (
    power_path.low_quiescent |-> !power_path.converter_on &&
    power_path.battery_switch_on && power_path.battery_switch_gate)
    else $error("high impedance path wrong");
  chk_run_quiet: assert property (
    power_path.charge_run |-> power_path.converter_on &&
    !power_path.low_quiescent)
    else $error("charging while quiet");
  chk_cd_rail: assert property (
    s_cd_mode |-> power_path.system_rail_target)
    else $error("rail not regulated with charge off");
  chk_supp_path: assert property (
    s_short_held |-> power_path.battery_switch_on &&
    power_path.battery_switch_gate)
    else $error("no supplement on short supply");
  chk_bat_range: assert property (
    vb != 13'h0000 |-> vb >= 13'h0dac && vb <= 13'h1158 &&
    (vb - 13'h0dac) % 13'h0014 == 13'h0000)
    else $error("battery target off grid");
  chk_ilim_set: assert property (
    hp_input_current_limit_ma inside {12'h000, 12'h5dc, 12'h9c4})
    else $error("input limit not 1.5 or 2.5 A");
  chk_chg_step: assert property (
    ic != 12'h000 |-> ic >= 12'h226 && ic <= 12'hb3b &&
    (ic - 12'h226) % 12'h04b == 12'h000)
    else $error("fast charge off grid");
  chk_term_step: assert property (
    it != 12'h000 |-> it <= 12'h190 && it % 12'h032 == 12'h000)
    else $error("termination off grid");
  chk_dpm_step: assert property (
    usb_input_power_limit_mv != 13'h0000 |->
    usb_input_power_limit_mv inside {[13'h1068:13'h1298]} &&
    hp_input_power_limit_mv inside {[13'h1068:13'h1298]} &&
    (usb_input_power_limit_mv - 13'h1068) % 13'h0050 == 13'h0000 &&
    (hp_input_power_limit_mv - 13'h1068) % 13'h0050 == 13'h0000)
    else $error("power limit threshold off grid");
  chk_detect_clr: assert property (
    s_done_held |-> ##[0:3] !usb_detect_force)
    else $error("detect force not cleared");
endmodule
bind ccr_cfg_regs ccr_cfg_regs_asserts i_chk (
  .sys_clk, .rst, .supply_short_pin, .usb_detect_done_pin, .power_path,
  .usb_detect_force, .battery_reg_target_mv, .hp_input_current_limit_ma,
  .fast_charge_current_ma, .termination_current_ma,
  .usb_input_power_limit_mv, .hp_input_power_limit_mv
);
`default_nettype wire

//--- dv/ccr_i2c_host.sv
// Purpose: Two-wire bus host model driving the register bank
// Assumes: Open-drain data line with pull-up resolved by the bench
// Notes:   Moves lines just after a clock edge; phases of 6+ cycles
`timescale 1ns/1ps
`default_nettype none
module ccr_i2c_host (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 6;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Data moves one edge after the clock fall, never with it
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    r = sda;
    scl <= 1'b0;
    tick(1);
  endtask
  // Long release so a device ACK is gone before the clock rises
  task automatic start_cond;
    sda_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop_cond;
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask
  task automatic byte_io(input logic [7:0] b, input logic last,
                         output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(last, a);
    ack = ~a;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                           input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, r, k0);
    byte_io(a, 1'b1, r, k1);
    byte_io(d, 1'b1, r, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] r;
    logic       k;
    start_cond();
    byte_io({ccr_pkg::DEV_ADDR, 1'b0}, 1'b1, r, k);
    byte_io(a, 1'b1, r, k);
    start_cond();
    byte_io({ccr_pkg::DEV_ADDR, 1'b1}, 1'b1, r, k);
    byte_io(8'hff, 1'b1, v, k);
    stop_cond();
  endtask
endmodule
`default_nettype wire

//--- dv/ccr_cfg_regs_bench.sv
// Purpose: Self-checking bench for the charger config register bank
// Assumes: Default identity parameters of the bank
// Notes:   Table rows first, then awkward cases, reset last
`timescale 1ns/1ps
`default_nettype none
module ccr_cfg_regs_bench;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  r;
    logic [1:0]  s;
    logic [12:0] x;
    logic [12:0] y;
  } ccr_row_t;
  logic               sys_clk, rst, scl, host_low, sda_out, sda_oe;
  logic               min_pin, lim_pin, short_pin, done_pin, force_o;
  ccr_pkg::ccr_power_t pp;
  logic [12:0]        bat, usb, hp;
  logic [11:0]        ilim, chg, term;
  logic [7:0]         v;
  logic               ok;
  int                 n_mismatch, check_count, cycles;
  wire                sda = ~(host_low | (sda_oe & ~sda_out));
  ccr_row_t rows [14] = '{
    '{8'h02, 8'h8c, 8'h8c, 2'h3, 13'h0036, 13'h003f},
    '{8'h02, 8'h8e, 8'h8e, 2'h3, 13'h0028, 13'h003f},
    '{8'h02, 8'h8f, 8'h8f, 2'h3, 13'h0007, 13'h0027},
    '{8'h02, 8'h8d, 8'h8d, 2'h3, 13'h0007, 13'h0027},
    '{8'h02, 8'h8c, 8'h8c, 2'h3, 13'h0036, 13'h003f},
    '{8'h03, 8'h00, 8'h00, 2'h0, 13'h0dac, 13'h05dc},
    '{8'h03, 8'h80, 8'h80, 2'h0, 13'h102c, 13'h05dc},
    '{8'h03, 8'hbe, 8'hbe, 2'h0, 13'h1158, 13'h09c4},
    '{8'h03, 8'hfe, 8'hfe, 2'h0, 13'h1158, 13'h09c4},
    '{8'h05, 8'hff, 8'hff, 2'h1, 13'h0b3b, 13'h0190},
    '{8'h05, 8'h00, 8'h00, 2'h1, 13'h0226, 13'h0032},
    '{8'h05, 8'h44, 8'h44, 2'h1, 13'h047e, 13'h00fa},
    '{8'h06, 8'h3f, 8'h3f, 2'h2, 13'h1298, 13'h1298},
    '{8'h06, 8'h11, 8'h11, 2'h2, 13'h1108, 13'h10b8}
  };
  ccr_cfg_regs i_dut (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .min_system_active_pin(min_pin),
    .input_power_limit_pin(lim_pin), .supply_short_pin(short_pin),
    .usb_detect_done_pin(done_pin), .power_path(pp),
    .usb_detect_force(force_o), .battery_reg_target_mv(bat),
    .hp_input_current_limit_ma(ilim), .fast_charge_current_ma(chg),
    .termination_current_ma(term), .usb_input_power_limit_mv(usb),
    .hp_input_power_limit_mv(hp)
  );
  ccr_i2c_host i_host (
    .sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(host_low)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ------------------------------------
  // Helpers
  // ------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [25:0] got, input logic [25:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(ccr_pkg::DEV_ADDR, a, d, ok);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.read_reg(a, v);
    check({18'h0, v}, {18'h0, e});
  endtask
  function automatic logic [25:0] seen(input logic [1:0] s,
                                       input logic [12:0] m);
    case (s)
      2'h0: seen = {bat, 1'b0, ilim};
      2'h1: seen = {1'b0, chg, 1'b0, term};
      2'h2: seen = {usb, hp};
      default: seen = {7'h00, pp & m[5:0], m};
    endcase
  endfunction
  task automatic chk_defaults;
    check(seen(2'h0, 13'h0), {13'h0e10, 13'h05dc});
    check(seen(2'h1, 13'h0), {13'h03e8, 13'h0096});
    check(seen(2'h2, 13'h0), {13'h1068, 13'h1068});
    check({20'h0, pp}, {20'h0, 6'h36});
    rd(8'h02, 8'h8c);
    rd(8'h03, 8'h14);
    rd(8'h05, 8'h32);
    rd(8'h06, 8'h00);
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    rst = 1'b1;
    {min_pin, lim_pin, short_pin, done_pin} = 4'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      check(seen(rows[i].s, rows[i].y), {rows[i].x, rows[i].y});
      rd(rows[i].a, rows[i].r);
    end
    $display("test table done");
    rd(8'h04, 8'hb3);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'hb3);
    $display("test identity done");
    min_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h06, 8'h91);
    min_pin <= 1'b0;
    lim_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h06, 8'h51);
    lim_pin <= 1'b0;
    $display("test flags done");
    wr(8'h03, 8'h15);
    check({25'h0, force_o}, {25'h0, 1'b1});
    rd(8'h03, 8'h15);
    done_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    done_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({25'h0, force_o}, {25'h0, 1'b0});
    rd(8'h03, 8'h14);
    $display("test detect done");
    wr(8'h02, 8'h8e);
    short_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check({20'h0, pp}, {20'h0, 6'h2e});
    short_pin <= 1'b0;
    wr(8'h02, 8'h8c);
    $display("test supplement done");
    i_host.write_reg(7'h6a, 8'h05, 8'hff, ok);
    check({25'h0, ok}, 26'h0);
    rd(8'h05, 8'h44);
    wr(8'h07, 8'h5a);
    rd(8'h07, 8'h00);
    $display("test refusal done");
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_defaults();
    $display("test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
